// ==== core/pwr_seq_pkg.sv ====
package pwr_seq_pkg;

  // ********************************************************************
  // Register map (indices; byte address is four times the index)
  // ********************************************************************
  localparam int NUM_SRC = 6;
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_PRIO_LO = 8'hB8;
  localparam logic [7:0] IDX_PRIO_HI = 8'hB7;
  localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
  localparam logic [7:0] IDX_WAKE_CFG = 8'hC0;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TMR2 = 5;
  localparam int PC_CPU_SLEEP = 0;
  localparam int PC_DEEP_SLEEP = 1;
  localparam int PC_FLAG0 = 2;
  localparam int PC_FLAG1 = 3;
  localparam int WC_EDGE0 = 8;
  localparam int WC_EDGE1 = 9;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [5:0] PRIO_RST = 6'h00;
  localparam logic [5:0] ENABLE_RST = 6'h00;
  localparam logic [1:0] EDGE_RST = 2'h0;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int OSC_PERIOD_PS = 5000;
  localparam int RESET_HOLD_PERIODS = 24;
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STAB_CYCLES_DEF = 256;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [4:0] {
    MODE_RUN     = 5'b00001,
    MODE_IDLE    = 5'b00010,
    MODE_PDOWN   = 5'b00100,
    MODE_STAB    = 5'b01000,
    MODE_RELEASE = 5'b10000
  } mode_t;

  typedef struct packed {
    logic take;
    logic [2:0] src;
    logic [1:0] lvl;
  } irq_grant_t;

  typedef struct packed {
    logic strobe_force;
    logic strobe_level;
    logic port0_float;
    logic port0_zero_only;
    logic port2_addr_sel;
    logic port_hold;
  } pin_mode_t;

endpackage

// ==== core/prio_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter
  import pwr_seq_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] lo,
  input wire logic [N-1:0] hi,
  output logic any,
  output logic [2:0] src,
  output logic [1:0] lvl
);

  logic [1:0] level [N];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lvl
      assign level[g] = {hi[g], lo[g]};
    end
  endgenerate

  // Scan from the last source down; a non-strict compare lets the
  // earliest source win ties
  always_comb begin
    any = 1'b0;
    src = 3'h0;
    lvl = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!any || level[i] >= lvl)) begin
        any = 1'b1;
        src = 3'(i);
        lvl = level[i];
      end
    end
  end

endmodule
`default_nettype wire

// ==== core/pwr_seq_top.sv ====
// Contract
// - Low and high priority bits per source, ext0 bit0 up to timer2 bit5.
// - High bit and low bit join into a two-bit level, 3 highest.
// - Higher level wins; only a lower level service may be preempted.
// - Low priority register at B8h, high priority register at B7h.
// - Bits 7 and 6 of both priority registers are unused, never set.
// - Deep-sleep at bit 1, CPU-sleep at bit 0; reset clears deep-sleep.
// - Writing CPU-sleep stops the CPU right after that write.
// - Idle gates only the CPU clock; interrupt logic keeps running.
// - CPU registers are kept in idle since its clock is gated.
// - Idle forces strobes high, holds ports; external code floats port 0.
// - Enabled interrupt clears CPU-sleep, ends idle, CPU resumes after.
// - Two general purpose flags are plain software storage.
// - Reset pin held 24 oscillator periods completes a reset.
// - Setting deep-sleep stops the oscillator after that write.
// - Registers and RAM keep contents throughout power-down.
// - Only enabled external inputs wake power-down, level or edge mode.
// - Low wake input restarts oscillator; its return high ends exit.
// - Either input restarts; first release exits; higher level served.
// - After servicing the wake interrupt the CPU resumes after entry.
// - Reset exit reinitialises registers; interrupt exit keeps them.
// - RAM stays intact over either power-down exit.
// - Both sleep bits set means power-down path; the interrupt exit clears both.
// - Power-down drives strobes low, holds ports, port 0 per memory.
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_top
  import pwr_seq_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_wake_0_n,
  input wire logic ext_wake_1_n,
  input wire logic reset_pin,
  input wire logic ext_code_pin,
  input wire logic [3:0] periph_req,
  input wire logic return_from_interrupt,
  output logic irq_take,
  output logic [2:0] irq_src,
  output logic [1:0] irq_lvl,
  output logic cpu_clk_en,
  output logic osc_run,
  output logic sfr_reset,
  output logic strobe_force,
  output logic strobe_level,
  output logic port0_float,
  output logic port0_zero_only,
  output logic port2_addr_sel,
  output logic port_hold
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    mode_t mode;
    logic [5:0] prio_lo;
    logic [5:0] prio_hi;
    logic [5:0] enable;
    logic [1:0] edge_sel;
    logic cpu_sleep;
    logic deep_sleep;
    logic flag0;
    logic flag1;
    logic [1:0] wake_m;
    logic [1:0] wake_s;
    logic [1:0] wake_d;
    logic [1:0] ext_flag;
    logic rst_m;
    logic rst_s;
    logic [4:0] rst_cnt;
    logic code_m;
    logic code_s;
    logic [15:0] stab_cnt;
    logic [3:0] in_service;
    irq_grant_t grant;
    pin_mode_t pins;
    logic cpu_clk_en;
    logic osc_run;
    logic sfr_reset;
    logic a_wr;
    logic a_rd;
    logic [7:0] a_idx;
    logic [31:0] hrdata;
  } state_t;

  localparam state_t STATE_RST = '{
    mode: MODE_RUN,
    prio_lo: PRIO_RST,
    prio_hi: PRIO_RST,
    enable: ENABLE_RST,
    edge_sel: EDGE_RST,
    wake_m: 2'h3,
    wake_s: 2'h3,
    wake_d: 2'h3,
    cpu_clk_en: 1'b1,
    osc_run: 1'b1,
    default: '0
  };

  localparam logic [15:0] STAB_LAST = 16'(STAB_CYCLES - 1);
  localparam logic [4:0] RST_LAST = 5'(RESET_HOLD_CYCLES - 1);

  state_t s_ff;
  state_t nxt_s;

  logic [5:0] pending;
  logic best_any;
  logic [2:0] best_src;
  logic [1:0] best_lvl;
  logic [1:0] ext_pend;
  logic [1:0] wake_low;
  logic [1:0] wake_rise;
  logic [1:0] wake_fall;
  logic [1:0] top_lvl;
  logic addr_take;

  // ********************************************************************
  // Request arbitration
  // ********************************************************************
  prio_arbiter #(
    .N(NUM_SRC)
  ) u_arb (
    .req(pending),
    .lo(s_ff.prio_lo),
    .hi(s_ff.prio_hi),
    .any(best_any),
    .src(best_src),
    .lvl(best_lvl)
  );

  always_comb begin
    wake_low = ~s_ff.wake_s;
    wake_fall = s_ff.wake_d & ~s_ff.wake_s;
    wake_rise = ~s_ff.wake_d & s_ff.wake_s;
    // Level mode requests while low; a latched flag covers edges and exits
    ext_pend = s_ff.ext_flag | (~s_ff.edge_sel & wake_low);
    pending = '0;
    pending[SRC_EXT0] = ext_pend[0];
    pending[SRC_TMR0] = periph_req[0];
    pending[SRC_EXT1] = ext_pend[1];
    pending[SRC_TMR1] = periph_req[1];
    pending[SRC_SERIAL] = periph_req[2];
    pending[SRC_TMR2] = periph_req[3];
    pending = pending & s_ff.enable;
    top_lvl = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (s_ff.in_service[i]) begin
        top_lvl = 2'(i);
      end
    end
    addr_take = hsel & hready & htrans[1];
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.grant.take = 1'b0;
    nxt_s.sfr_reset = 1'b0;

    // Pins from outside pass two flip-flops first
    nxt_s.wake_m = {ext_wake_1_n, ext_wake_0_n};
    nxt_s.wake_s = s_ff.wake_m;
    nxt_s.wake_d = s_ff.wake_s;
    nxt_s.rst_m = reset_pin;
    nxt_s.rst_s = s_ff.rst_m;
    nxt_s.code_m = ext_code_pin;
    nxt_s.code_s = s_ff.code_m;

    // Return first so a grant in the same cycle keeps its level
    if (return_from_interrupt) begin
      nxt_s.in_service[top_lvl] = 1'b0;
    end

    // Register writes in the data phase
    if (s_ff.a_wr) begin
      unique case (s_ff.a_idx)
        IDX_PRIO_LO: nxt_s.prio_lo = hwdata[5:0];
        IDX_PRIO_HI: nxt_s.prio_hi = hwdata[5:0];
        IDX_POWER_CTRL: begin
          nxt_s.cpu_sleep = hwdata[PC_CPU_SLEEP];
          nxt_s.deep_sleep = hwdata[PC_DEEP_SLEEP];
          nxt_s.flag0 = hwdata[PC_FLAG0];
          nxt_s.flag1 = hwdata[PC_FLAG1];
        end
        IDX_WAKE_CFG: begin
          nxt_s.enable = hwdata[5:0];
          nxt_s.edge_sel = {hwdata[WC_EDGE1], hwdata[WC_EDGE0]};
        end
        default: begin
        end
      endcase
    end

    // Edge mode latches a falling edge in every mode
    nxt_s.ext_flag = nxt_s.ext_flag | (s_ff.edge_sel & wake_fall);

    unique case (s_ff.mode)
      MODE_RUN: begin
        if (best_any && (s_ff.in_service == 4'h0 || best_lvl > top_lvl)) begin
          nxt_s.grant.take = 1'b1;
          nxt_s.grant.src = best_src;
          nxt_s.grant.lvl = best_lvl;
          nxt_s.in_service[best_lvl] = 1'b1;
          // Clear only what was taken; a new edge in this cycle still counts
          if (best_src == 3'(SRC_EXT0)) begin
            nxt_s.ext_flag[0] = s_ff.edge_sel[0] & wake_fall[0];
          end
          if (best_src == 3'(SRC_EXT1)) begin
            nxt_s.ext_flag[1] = s_ff.edge_sel[1] & wake_fall[1];
          end
        end
        if (nxt_s.deep_sleep) begin
          nxt_s.mode = MODE_PDOWN;
        end else if (nxt_s.cpu_sleep) begin
          nxt_s.mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (best_any) begin
          nxt_s.cpu_sleep = 1'b0;
          nxt_s.mode = MODE_RUN;
        end
      end
      MODE_PDOWN: begin
        if ((wake_low & {s_ff.enable[SRC_EXT1], s_ff.enable[SRC_EXT0]}) != 2'h0)
        begin
          nxt_s.mode = MODE_STAB;
          nxt_s.stab_cnt = STAB_LAST;
        end
      end
      MODE_STAB: begin
        // Waker keeps its input low for at least this wait
        if (s_ff.stab_cnt == 16'h0000) begin
          nxt_s.mode = MODE_RELEASE;
        end else begin
          nxt_s.stab_cnt = s_ff.stab_cnt - 16'h0001;
        end
      end
      MODE_RELEASE: begin
        if ((wake_rise & {s_ff.enable[SRC_EXT1], s_ff.enable[SRC_EXT0]}) != 2'h0)
        begin
          // First input to return high completes the exit and stays pending
          nxt_s.ext_flag = nxt_s.ext_flag | (wake_rise &
            {s_ff.enable[SRC_EXT1], s_ff.enable[SRC_EXT0]});
          nxt_s.cpu_sleep = 1'b0;
          nxt_s.deep_sleep = 1'b0;
          nxt_s.mode = MODE_RUN;
        end
      end
      default: nxt_s.mode = MODE_RUN;
    endcase

    // ******************************************************************
    // Reset pin: registers reinitialise, RAM untouched
    // ******************************************************************
    if (s_ff.rst_s) begin
      if (s_ff.rst_cnt != RST_LAST) begin
        nxt_s.rst_cnt = s_ff.rst_cnt + 5'h01;
      end else begin
        nxt_s.sfr_reset = 1'b1;
        nxt_s.mode = MODE_RUN;
        nxt_s.prio_lo = PRIO_RST;
        nxt_s.prio_hi = PRIO_RST;
        nxt_s.enable = ENABLE_RST;
        nxt_s.edge_sel = EDGE_RST;
        nxt_s.cpu_sleep = 1'b0;
        nxt_s.deep_sleep = 1'b0;
        nxt_s.flag0 = 1'b0;
        nxt_s.flag1 = 1'b0;
        nxt_s.ext_flag = 2'h0;
        nxt_s.in_service = 4'h0;
        nxt_s.grant.take = 1'b0;
      end
    end else begin
      nxt_s.rst_cnt = 5'h00;
    end

    // ******************************************************************
    // Clocks and pin modes follow the next mode
    // ******************************************************************
    // Gating the CPU clock freezes every CPU register in place
    nxt_s.cpu_clk_en = (nxt_s.mode == MODE_RUN);
    // Registers here run on the bus clock, so they hold through power-down
    nxt_s.osc_run = (nxt_s.mode != MODE_PDOWN);
    nxt_s.pins = '0;
    unique case (nxt_s.mode)
      MODE_RUN: begin
      end
      MODE_IDLE: begin
        nxt_s.pins.strobe_force = 1'b1;
        nxt_s.pins.strobe_level = 1'b1;
        nxt_s.pins.port_hold = 1'b1;
        nxt_s.pins.port0_float = s_ff.code_s;
        nxt_s.pins.port0_zero_only = ~s_ff.code_s;
        nxt_s.pins.port2_addr_sel = s_ff.code_s;
      end
      default: begin
        nxt_s.pins.strobe_force = 1'b1;
        nxt_s.pins.strobe_level = 1'b0;
        nxt_s.pins.port_hold = 1'b1;
        nxt_s.pins.port0_float = s_ff.code_s;
        nxt_s.pins.port0_zero_only = ~s_ff.code_s;
      end
    endcase

    // ******************************************************************
    // Bus address phase; reads see this cycle's write
    // ******************************************************************
    nxt_s.a_wr = addr_take & hwrite;
    nxt_s.a_rd = addr_take & ~hwrite;
    nxt_s.a_idx = haddr[9:2];
    if (haddr[ADDR_W-1:10] != '0) begin
      nxt_s.a_idx = 8'h00;
    end
    if (addr_take & ~hwrite) begin
      nxt_s.hrdata = 32'h0000_0000;
      unique case (nxt_s.a_idx)
        IDX_PRIO_LO: nxt_s.hrdata[5:0] = nxt_s.prio_lo;
        IDX_PRIO_HI: nxt_s.hrdata[5:0] = nxt_s.prio_hi;
        IDX_POWER_CTRL: begin
          nxt_s.hrdata[PC_CPU_SLEEP] = nxt_s.cpu_sleep;
          nxt_s.hrdata[PC_DEEP_SLEEP] = nxt_s.deep_sleep;
          nxt_s.hrdata[PC_FLAG0] = nxt_s.flag0;
          nxt_s.hrdata[PC_FLAG1] = nxt_s.flag1;
        end
        IDX_WAKE_CFG: begin
          nxt_s.hrdata[5:0] = nxt_s.enable;
          nxt_s.hrdata[WC_EDGE0] = nxt_s.edge_sel[0];
          nxt_s.hrdata[WC_EDGE1] = nxt_s.edge_sel[1];
        end
        default: begin
        end
      endcase
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= STATE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign hrdata = s_ff.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq_take = s_ff.grant.take;
  assign irq_src = s_ff.grant.src;
  assign irq_lvl = s_ff.grant.lvl;
  assign cpu_clk_en = s_ff.cpu_clk_en;
  assign osc_run = s_ff.osc_run;
  assign sfr_reset = s_ff.sfr_reset;
  assign strobe_force = s_ff.pins.strobe_force;
  assign strobe_level = s_ff.pins.strobe_level;
  assign port0_float = s_ff.pins.port0_float;
  assign port0_zero_only = s_ff.pins.port0_zero_only;
  assign port2_addr_sel = s_ff.pins.port2_addr_sel;
  assign port_hold = s_ff.pins.port_hold;

endmodule
`default_nettype wire

// ==== verification/pwr_seq_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_assertions
  import pwr_seq_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = STAB_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic reset_pin,
  input wire logic irq_take,
  input wire logic cpu_clk_en,
  input wire logic osc_run,
  input wire logic sfr_reset,
  input wire logic strobe_force,
  input wire logic strobe_level,
  input wire logic port_hold
);
  // ******************************
  // Helper counters
  // ******************************
  logic [5:0] hold_ff;
  logic [15:0] stab_ff;
  logic rd_prio_ff;
  logic wr_pc_ff;
  logic adr_ok;
  logic [9:0] idx;
  assign adr_ok = hsel && hready && htrans[1];
  assign idx = haddr[ADDR_W-1:2];
  // Counters saturate so a long hold never wraps into a false short one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_ff <= 6'h00;
      stab_ff <= 16'h0000;
      rd_prio_ff <= 1'b0;
      wr_pc_ff <= 1'b0;
    end else begin
      hold_ff <= !reset_pin ? 6'h00 : hold_ff + {5'h00, hold_ff != 6'h3F};
      stab_ff <= !osc_run ? 16'h0000 : stab_ff + {15'h0000, stab_ff != 16'hFFFF};
      rd_prio_ff <= adr_ok && !hwrite &&
        (idx == {2'b00, IDX_PRIO_LO} || idx == {2'b00, IDX_PRIO_HI});
      wr_pc_ff <= adr_ok && hwrite && idx == {2'b00, IDX_POWER_CTRL};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ******************************
  // Checks
  // ******************************
  chk_prio_spare:
    assert property (rd_prio_ff |-> hrdata[7:6] == 2'b00)
    else $error("priority spare bits read nonzero");
  chk_take_awake:
    assert property (irq_take |-> cpu_clk_en && osc_run)
    else $error("interrupt vectored while asleep");
  chk_idle_pins:
    assert property (strobe_force && strobe_level |->
      port_hold && !cpu_clk_en && osc_run)
    else $error("idle pin state wrong");
  chk_pd_pins:
    assert property (!osc_run |->
      strobe_force && !strobe_level && port_hold && !cpu_clk_en)
    else $error("power-down pin state wrong");
  chk_idle_entry:
    assert property (wr_pc_ff && hwdata[0] && !hwdata[1] |->
      ##[1:3] !cpu_clk_en)
    else $error("idle not entered after sleep write");
  chk_pd_entry:
    assert property (wr_pc_ff && hwdata[1] |-> ##[1:3] !osc_run)
    else $error("oscillator not stopped after deep sleep write");
  chk_stab_wait:
    // A reset exit restarts the clock without the wake wait
    assert property ($rose(cpu_clk_en) && !sfr_reset |->
      stab_ff >= STAB_CYCLES)
    else $error("cpu restarted before oscillator settled");
  chk_reset_hold:
    assert property ($rose(sfr_reset) |->
      hold_ff >= RESET_HOLD_CYCLES && hold_ff <= 29)
    else $error("reset completed at wrong hold length");
  chk_reset_done:
    assert property (hold_ff == 6'h28 |-> sfr_reset)
    else $error("long reset hold did not reset");
  cov_take: cover property (irq_take);
  cov_pd: cover property ($fell(osc_run));
  cov_rst: cover property ($rose(sfr_reset));
endmodule

bind pwr_seq_top pwr_seq_assertions #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hwdata(hwdata),
  .hrdata(hrdata),
  .reset_pin(reset_pin),
  .irq_take(irq_take),
  .cpu_clk_en(cpu_clk_en),
  .osc_run(osc_run),
  .sfr_reset(sfr_reset),
  .strobe_force(strobe_force),
  .strobe_level(strobe_level),
  .port_hold(port_hold)
);
`default_nettype wire

// ==== verification/cpu_pins_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_pins_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic irq_take,
  input wire logic [1:0] pull_low,
  input wire logic [7:0] svc_cycles,
  output logic ext_wake_0_n,
  output logic ext_wake_1_n,
  output logic return_from_interrupt
);
  // ******************************
  // Wake pins and service returns
  // ******************************
  logic [7:0] cnt_ff;
  logic [3:0] depth_ff;
  // Pins have pull-ups, a released pin reads high; the bench holds a
  // pin low past the settle time before letting go
  assign ext_wake_0_n = !pull_low[0];
  assign ext_wake_1_n = !pull_low[1];
  // Nested services return innermost first, each after svc_cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 8'h00;
      depth_ff <= 4'h0;
      return_from_interrupt <= 1'b0;
    end else begin
      return_from_interrupt <= 1'b0;
      if (irq_take) begin
        depth_ff <= depth_ff + 4'h1;
        cnt_ff <= svc_cycles;
      end else if (depth_ff != 4'h0) begin
        if (cnt_ff == 8'h00) begin
          return_from_interrupt <= 1'b1;
          depth_ff <= depth_ff - 4'h1;
          cnt_ff <= svc_cycles;
        end else begin
          cnt_ff <= cnt_ff - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/pwr_seq_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_top_test;
  import pwr_seq_pkg::*;
  localparam int STAB = 4;
  localparam logic [11:0] A_LO = {2'b00, IDX_PRIO_LO, 2'b00};
  localparam logic [11:0] A_HI = {2'b00, IDX_PRIO_HI, 2'b00};
  localparam logic [11:0] A_PC = {2'b00, IDX_POWER_CTRL, 2'b00};
  localparam logic [11:0] A_WC = {2'b00, IDX_WAKE_CFG, 2'b00};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ext_code_pin = 1'b0;
  logic reset_pin = 1'b0;
  logic [3:0] periph_req = 4'h0;
  logic [1:0] pull_low = 2'h0;
  logic [7:0] svc = 8'h08;
  logic [31:0] hrdata;
  logic hreadyout, hresp, wake0_n, wake1_n, rfi, irq_take;
  logic [2:0] irq_src;
  logic [1:0] irq_lvl;
  logic cpu_clk_en, osc_run, sfr_reset, s_force, s_level;
  logic p0_float, p0_zero, p2_addr, p_hold, got, sfr_seen;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [5:0] lo_t [4] = '{6'h00, 6'h20, 6'h08, 6'h0A};
  logic [5:0] hi_t [4] = '{6'h00, 6'h00, 6'h10, 6'h0A};
  logic [2:0] src_t [4] = '{3'h1, 3'h5, 3'h4, 3'h1};
  logic [1:0] lvl_t [4] = '{2'h0, 2'h1, 2'h2, 2'h3};

  pwr_seq_top #(.STAB_CYCLES(STAB)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_wake_0_n(wake0_n), .ext_wake_1_n(wake1_n),
    .reset_pin(reset_pin), .ext_code_pin(ext_code_pin),
    .periph_req(periph_req), .return_from_interrupt(rfi),
    .irq_take(irq_take), .irq_src(irq_src), .irq_lvl(irq_lvl),
    .cpu_clk_en(cpu_clk_en), .osc_run(osc_run), .sfr_reset(sfr_reset),
    .strobe_force(s_force), .strobe_level(s_level),
    .port0_float(p0_float), .port0_zero_only(p0_zero),
    .port2_addr_sel(p2_addr), .port_hold(p_hold));
  cpu_pins_model u_cpu (
    .hclk(hclk), .hresetn(hresetn), .irq_take(irq_take),
    .pull_low(pull_low), .svc_cycles(svc), .ext_wake_0_n(wake0_n),
    .ext_wake_1_n(wake1_n), .return_from_interrupt(rfi));

  always #2.5 hclk = ~hclk;

  // ******************************
  // Tasks
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  // Bounded wait for a vectoring pulse, then its source and level
  task automatic take(input int max, input logic [2:0] s,
                      input logic [1:0] l, input logic want);
    got = 1'b0;
    // Look mid-cycle: the pulse stands one cycle, an edge read races it
    for (int i = 0; i < max && !got; i++) begin
      @(negedge hclk);
      got = (irq_take === 1'b1);
    end
    if (want) begin
      check({26'h0, got, irq_src, irq_lvl}, {26'h0, 1'b1, s, l});
    end else begin
      check({31'h0, got}, 32'h0);
    end
    @(posedge hclk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (sfr_reset === 1'b1) sfr_seen = 1'b1;
    if (cyc == 6000) begin
      err_count++;
      $display("Error %0t: run too long", $time);
      end_sim();
    end
  end

  // ******************************
  // Tests
  // ******************************
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(A_LO, 32'h0);
    rd(A_HI, 32'h0);
    rd(A_PC, 32'h0);
    wr(12'h004, 32'hFFFFFFFF);
    rd(12'h004, 32'h0);
    wr(A_LO, 32'h3F);
    rd(A_LO, 32'h3F);
    wr(A_HI, 32'h05);
    rd(A_HI, 32'h05);
    wr(A_WC, 32'h3F);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      wr(A_LO, {26'h0, lo_t[i]});
      wr(A_HI, {26'h0, hi_t[i]});
      periph_req <= 4'hF;
      take(8, src_t[i], lvl_t[i], 1'b1);
      periph_req <= 4'h0;
      repeat (40) @(posedge hclk);
    end
    wr(A_LO, 32'h0);
    wr(A_HI, 32'h20);
    svc <= 8'h3C;
    periph_req <= 4'h1;
    take(8, 3'h1, 2'h0, 1'b1);
    periph_req <= 4'h8;
    take(8, 3'h5, 2'h2, 1'b1);
    periph_req <= 4'h2;
    take(20, 3'h3, 2'h0, 1'b0);
    check({31'h0, got}, 32'h0);
    take(200, 3'h3, 2'h0, 1'b1);
    periph_req <= 4'h0;
    svc <= 8'h08;
    repeat (80) @(posedge hclk);
    $display("priority test done");
    ext_code_pin <= 1'b1;
    wr(A_PC, 32'h0D);
    repeat (4) @(posedge hclk);
    check({cpu_clk_en, osc_run, s_force, s_level, p0_float, p2_addr,
           p_hold, hresp}, 8'h7E);
    rd(A_PC, 32'h0D);
    periph_req <= 4'h4;
    take(12, 3'h4, 2'h0, 1'b1);
    periph_req <= 4'h0;
    rd(A_PC, 32'h0C);
    repeat (20) @(posedge hclk);
    $display("idle test done");
    ext_code_pin <= 1'b0;
    wr(A_HI, 32'h04);
    wr(A_PC, 32'h0F);
    repeat (4) @(posedge hclk);
    check({cpu_clk_en, osc_run, s_force, s_level, p0_float, p0_zero,
           p_hold}, 7'h13);
    rd(A_HI, 32'h04);
    pull_low <= 2'h3;
    for (int i = 0; i < 10 && osc_run !== 1'b1; i++) @(posedge hclk);
    check({osc_run, cpu_clk_en}, 2'h2);
    repeat (STAB + 10) @(posedge hclk);
    pull_low <= 2'h2;
    take(12, 3'h2, 2'h2, 1'b1);
    pull_low <= 2'h0;
    take(40, 3'h0, 2'h0, 1'b1);
    rd(A_PC, 32'h0C);
    rd(A_HI, 32'h04);
    repeat (20) @(posedge hclk);
    $display("power-down test done");
    sfr_seen = 1'b0;
    wr(A_PC, 32'h0B);
    reset_pin <= 1'b1;
    repeat (22) @(posedge hclk);
    reset_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    check({31'h0, sfr_seen}, 32'h0);
    wr(A_PC, 32'h01);
    reset_pin <= 1'b1;
    repeat (40) @(posedge hclk);
    reset_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    check({sfr_seen, cpu_clk_en}, 2'h3);
    rd(A_HI, 32'h0);
    rd(A_PC, 32'h0);
    $display("reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
